// *** design/slcdw_pkg.sv ***
// Summary of operation
// - link is write-only, no return line
// - data bytes sent with select high
// - command bytes sent with select low
// - initialization commands precede any data
// - 0xC0-0xCF selects common output mode
// - 0x28-0x2F sets power control
// - 0x40-0x7F sets display start line
// - 0xB0-0xB8 selects page address
// - 0x00-0x18 sets column address
// - 0xAE display off, 0xAF on
// - eight pages; address before streaming data
// - transmit-only master at 3.125 MHz
package slcdw_pkg;
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned SCLK_HZ      = 3_125_000;
  // half period of the serial clock in system cycles
  localparam int unsigned HALF_CYC     = CLK_HZ / SCLK_HZ / 2;
  localparam int unsigned BYTE_BITS    = 8;
  localparam int unsigned PAGES        = 8;
  localparam logic [7:0]  CMD_COM_MODE = 8'hC0;
  localparam logic [7:0]  CMD_POWER    = 8'h2F;
  localparam logic [7:0]  CMD_START    = 8'h40;
  localparam logic [7:0]  CMD_PAGE     = 8'hB0;
  localparam logic [7:0]  CMD_PAGE_MAX = 8'hB8;
  localparam logic [7:0]  CMD_COL_MAX  = 8'h18;
  localparam logic [7:0]  CMD_DISP_OFF = 8'hAE;
  localparam logic [7:0]  CMD_DISP_ON  = 8'hAF;
  localparam int unsigned INIT_LEN     = 6;
  localparam int unsigned RST_CYC      = 64;

  typedef struct packed {
    logic       is_data;
    logic [7:0] value;
  } slcdw_byte_s;

  typedef struct packed {
    logic sclk;
    logic ss_n;
    logic mosi;
    logic dc;
  } slcdw_pins_s;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_INIT  = 3'h1,
    ST_IDLE  = 3'h2,
    ST_SEND  = 3'h3,
    ST_GAP   = 3'h4
  } slcdw_state_e;
endpackage

// *** design/slcdw_shift.sv ***
`timescale 1ns/1ps
// byte serialiser: mode 0, msb first, select framed per byte
module slcdw_shift #(
  parameter int unsigned HALF = slcdw_pkg::HALF_CYC
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   start_i,
  input  wire slcdw_pkg::slcdw_byte_s byte_i,
  output logic                        busy_o,
  output logic                        done_o,
  output slcdw_pkg::slcdw_pins_s      pins_o
);
  // the divider counter is 16 bits wide, so the half period must fit in it
  if (HALF < 1 || HALF > 65536) begin : g_bad_half
    $error("half period out of range");
  end

  logic [15:0] div_q;
  logic [3:0]  edge_q;
  logic [7:0]  sh_q;
  logic        act_q;

  // half period timer and edge count, 16 edges per byte
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q  <= 16'h0000;
      edge_q <= 4'h0;
      act_q  <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!act_q) begin
        if (start_i) begin
          act_q  <= 1'b1;
          div_q  <= 16'h0000;
          edge_q <= 4'h0;
        end
      end else if (div_q == 16'(HALF - 1)) begin
        div_q  <= 16'h0000;
        edge_q <= edge_q + 4'h1;
        if (edge_q == 4'hF) begin
          act_q  <= 1'b0;
          done_o <= 1'b1;
        end
      end else begin
        div_q <= div_q + 16'h0001;
      end
    end
  end

  // pins: select low for the byte, clock rises mid-bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_o <= '{sclk: 1'b0, ss_n: 1'b1, mosi: 1'b0, dc: 1'b0};
      sh_q   <= 8'h00;
    end else if (!act_q && start_i) begin
      pins_o.ss_n <= 1'b0;
      pins_o.dc   <= byte_i.is_data;
      pins_o.mosi <= byte_i.value[7];
      sh_q        <= {byte_i.value[6:0], 1'b0};
    end else if (act_q && div_q == 16'(HALF - 1)) begin
      pins_o.sclk <= ~edge_q[0];
      if (edge_q[0] && edge_q != 4'hF) begin
        pins_o.mosi <= sh_q[7];
        sh_q        <= {sh_q[6:0], 1'b0};
      end
      if (edge_q == 4'hF) pins_o.ss_n <= 1'b1;
    end
  end

  assign busy_o = act_q;

  a_dc_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!pins_o.ss_n && !$past(pins_o.ss_n)) |-> $stable(pins_o.dc))
    else $error("select changed inside a byte");
  a_done_frame: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done_o |-> pins_o.ss_n && !pins_o.sclk)
    else $error("byte ended with bad pin levels");
endmodule

// *** design/slcdw_top.sv ***
`timescale 1ns/1ps
// host side writer for the graphic display; no read path exists
module slcdw_top (
  input  wire logic       CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic       BACKLIGHT_REQ_I,
  input  wire logic       SEND_VALID_I,
  input  wire logic       SEND_IS_DATA_I,
  input  wire logic [7:0] SEND_BYTE_I,
  output logic            SEND_READY_O,
  output logic            INIT_DONE_O,
  output logic [2:0]      PAGE_O,
  output logic [7:0]      COLUMN_O,
  output logic            LCD_SERIAL_CLOCK_O,
  output logic            LCD_SLAVE_SELECT_N_O,
  output logic            LCD_SERIAL_OUT_O,
  output logic            DATA_COMMAND_SELECT_O,
  output logic            LCD_RESET_N_O,
  output logic            BACKLIGHT_ON_O
);
  logic                   rst_m_q;
  logic                   rst_s_q;
  logic                   rst_n;
  slcdw_pkg::slcdw_state_e state_q;
  logic [7:0]             cnt_q;
  logic [2:0]             init_idx_q;
  logic                   start;
  slcdw_pkg::slcdw_byte_s cur;
  logic                   busy;
  logic                   done;
  slcdw_pkg::slcdw_pins_s pins;
  logic                   bl_q;
  logic [10:0]            frame_q;

  // reset release through two flops
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  assign rst_n = rst_s_q;

  // init command table
  function automatic logic [7:0] init_cmd(input logic [2:0] i);
    case (i)
      3'h0:    init_cmd = slcdw_pkg::CMD_COM_MODE;
      3'h1:    init_cmd = slcdw_pkg::CMD_POWER;
      3'h2:    init_cmd = slcdw_pkg::CMD_START;
      3'h3:    init_cmd = slcdw_pkg::CMD_PAGE;
      3'h4:    init_cmd = 8'h00;
      default: init_cmd = slcdw_pkg::CMD_DISP_ON;
    endcase
  endfunction

  // sequencer: reset pulse, init list, then user bytes
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= slcdw_pkg::ST_RESET;
      cnt_q      <= 8'h00;
      init_idx_q <= 3'h0;
      INIT_DONE_O <= 1'b0;
      LCD_RESET_N_O <= 1'b0;
    end else begin
      case (state_q)
        slcdw_pkg::ST_RESET: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(slcdw_pkg::RST_CYC - 1)) begin
            LCD_RESET_N_O <= 1'b1;
            cnt_q   <= 8'h00;
            state_q <= slcdw_pkg::ST_GAP;
          end
        end
        // settle time after the display leaves reset
        slcdw_pkg::ST_GAP: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(slcdw_pkg::RST_CYC - 1)) begin
            cnt_q   <= 8'h00;
            state_q <= slcdw_pkg::ST_INIT;
          end
        end
        // one init byte per frame; the next starts after done
        slcdw_pkg::ST_INIT: begin
          if (done) begin
            if (init_idx_q == 3'(slcdw_pkg::INIT_LEN - 1)) begin
              INIT_DONE_O <= 1'b1;
              state_q     <= slcdw_pkg::ST_IDLE;
            end else begin
              init_idx_q <= init_idx_q + 3'h1;
            end
          end
        end
        slcdw_pkg::ST_IDLE: begin
          if (SEND_VALID_I) state_q <= slcdw_pkg::ST_SEND;
        end
        slcdw_pkg::ST_SEND: begin
          if (done) state_q <= slcdw_pkg::ST_IDLE;
        end
        default: state_q <= slcdw_pkg::ST_RESET;
      endcase
    end
  end

  // pick the byte; data only after init
  always_comb begin
    cur   = '{is_data: 1'b0, value: init_cmd(init_idx_q)};
    start = 1'b0;
    if (state_q == slcdw_pkg::ST_INIT) begin
      // held off in the done cycle so the index can advance first
      start = !busy && !done;
    end else if (state_q == slcdw_pkg::ST_IDLE) begin
      cur   = '{is_data: SEND_IS_DATA_I, value: SEND_BYTE_I};
      start = SEND_VALID_I;
    end
  end
  assign SEND_READY_O = (state_q == slcdw_pkg::ST_IDLE);

  // address tracking from sent commands and data
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PAGE_O   <= 3'h0;
      COLUMN_O <= 8'h00;
    end else if (start && state_q == slcdw_pkg::ST_IDLE) begin
      if (cur.is_data) begin
        COLUMN_O <= COLUMN_O + 8'h01;
      end else if (cur.value >= slcdw_pkg::CMD_PAGE && cur.value <= slcdw_pkg::CMD_PAGE_MAX) begin
        PAGE_O <= cur.value[2:0];
      end else if (cur.value <= slcdw_pkg::CMD_COL_MAX) begin
        COLUMN_O <= cur.value;
      end
    end
  end

  // backlight level follows request
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) bl_q <= 1'b0;
    else        bl_q <= BACKLIGHT_REQ_I;
  end
  assign BACKLIGHT_ON_O = bl_q;

  // serialiser, transmit only at the divided rate
  slcdw_shift #(
    .HALF (slcdw_pkg::HALF_CYC)
  ) u_shift (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .start_i (start),
    .byte_i  (cur),
    .busy_o  (busy),
    .done_o  (done),
    .pins_o  (pins)
  );

  assign LCD_SERIAL_CLOCK_O    = pins.sclk;
  assign LCD_SLAVE_SELECT_N_O  = pins.ss_n;
  assign LCD_SERIAL_OUT_O      = pins.mosi;
  assign DATA_COMMAND_SELECT_O = pins.dc;

  // frame timer for the checks: sampled select-low cycles of the current byte;
  // eleven flops, but it catches a divider or edge count that drifts
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      frame_q <= 11'h000;
    end else if (LCD_SLAVE_SELECT_N_O) begin
      frame_q <= 11'h000;
    end else begin
      frame_q <= frame_q + 11'h001;
    end
  end

  a_no_data_early: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (!LCD_SLAVE_SELECT_N_O && DATA_COMMAND_SELECT_O) |-> INIT_DONE_O)
    else $error("data sent before init");
  a_col_step: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (start && state_q == slcdw_pkg::ST_IDLE && cur.is_data) |=> COLUMN_O == $past(COLUMN_O) + 8'h01)
    else $error("column did not advance");
  a_bl_follow: assert property (@(posedge CLK_I) disable iff (!rst_n)
    ##1 BACKLIGHT_ON_O == $past(BACKLIGHT_REQ_I))
    else $error("backlight mismatch");
  a_rst_held: assert property (@(posedge CLK_I) disable iff (!rst_n)
    state_q == slcdw_pkg::ST_RESET |-> !LCD_RESET_N_O)
    else $error("display reset released early");
  a_init_cmd: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (state_q == slcdw_pkg::ST_INIT && !LCD_SLAVE_SELECT_N_O) |-> !DATA_COMMAND_SELECT_O)
    else $error("init byte not a command");
  a_page_range: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (start && state_q == slcdw_pkg::ST_IDLE && !cur.is_data && cur.value == slcdw_pkg::CMD_PAGE_MAX)
      |=> PAGE_O == 3'h0)
    else $error("page decode wrong");

  // pin level checks: the clock rests low between bytes, each frame is one byte long
  a_sclk_idle: assert property (@(posedge CLK_I) disable iff (!rst_n)
    LCD_SLAVE_SELECT_N_O |-> !LCD_SERIAL_CLOCK_O)
    else $error("serial clock moved outside a frame");
  a_frame_len: assert property (@(posedge CLK_I) disable iff (!rst_n)
    $rose(LCD_SLAVE_SELECT_N_O) |-> frame_q == 11'(2 * slcdw_pkg::BYTE_BITS * slcdw_pkg::HALF_CYC))
    else $error("frame length wrong");

  // handshake checks: one byte in flight, nothing offered before init
  a_one_byte: assert property (@(posedge CLK_I) disable iff (!rst_n)
    SEND_READY_O |-> LCD_SLAVE_SELECT_N_O)
    else $error("ready raised inside a frame");
  a_init_order: assert property (@(posedge CLK_I) disable iff (!rst_n)
    SEND_READY_O |-> INIT_DONE_O)
    else $error("ready before init finished");
  a_lcd_live: assert property (@(posedge CLK_I) disable iff (!rst_n)
    INIT_DONE_O |-> LCD_RESET_N_O)
    else $error("display held in reset after init");

  // address checks against the byte taken; the page keeps only three bits
  a_page_set: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (start && state_q == slcdw_pkg::ST_IDLE && !cur.is_data && cur.value[7:3] == 5'h16)
      |=> PAGE_O == 3'($past(SEND_BYTE_I)))
    else $error("page not taken from command");
  a_col_set: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (start && state_q == slcdw_pkg::ST_IDLE && !cur.is_data && cur.value <= slcdw_pkg::CMD_COL_MAX)
      |=> COLUMN_O == $past(SEND_BYTE_I))
    else $error("column not taken from command");
endmodule

// *** tb/slcdw_lcd_model.sv ***
`timescale 1ns/1ps
// behavioural display: msb first on rising serial clock inside a frame
module slcdw_lcd_model (
  input  wire logic       sclk_i,
  input  wire logic       ss_n_i,
  input  wire logic       mosi_i,
  input  wire logic       dc_i,
  input  wire logic       rst_n_i,
  input  wire logic       bk_i,
  output logic            lit_o,
  output logic [7:0]      last_o,
  output logic            last_dc_o,
  output logic            on_o,
  output logic [2:0]      page_o,
  output logic [7:0]      col_o,
  output logic [7:0]      cnt_o
);
  logic [7:0] sh_q;
  logic [3:0] nb_q;
  assign lit_o = bk_i;
  // count restarts at each select fall; input only, nothing drives back toward the host
  always @(negedge ss_n_i or posedge sclk_i) begin
    if (!ss_n_i && !sclk_i) begin
      nb_q = 4'h0;
    end else if (!ss_n_i) begin
      sh_q = {sh_q[6:0], mosi_i};
      nb_q = nb_q + 4'h1;
    end
  end
  // decode whole bytes at frame end; partial frames are dropped
  always @(posedge ss_n_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_o <= 1'b0;
      page_o <= 3'h0;
      col_o <= 8'h00;
      cnt_o <= 8'h00;
    end else if (nb_q == 4'h8) begin
      last_o <= sh_q;
      last_dc_o <= dc_i;
      cnt_o <= cnt_o + 8'h01;
      // mode, power and start line codes hold no state here
      if (dc_i) col_o <= col_o + 8'h01;
      else if (sh_q == 8'hAE || sh_q == 8'hAF) on_o <= sh_q[0];
      else if (sh_q >= 8'hB0 && sh_q <= 8'hB8) page_o <= sh_q[2:0];
      else if (sh_q <= 8'h18) col_o <= sh_q;
    end
  end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
// drives the writer against the display model
module testbench;
  logic       clk, rst_n, bk_req, vld, is_data;
  logic [7:0] byte_v, column, m_last, m_col, m_cnt;
  logic [2:0] page, m_page;
  logic       rdy, idone, sclk, ss_n, mosi, dc, lrst_n, bk, m_lit, m_dc, m_on;
  int         errors, n_checks;
  slcdw_top uut (
    .CLK_I                 (clk),
    .RST_N_I               (rst_n),
    .BACKLIGHT_REQ_I       (bk_req),
    .SEND_VALID_I          (vld),
    .SEND_IS_DATA_I        (is_data),
    .SEND_BYTE_I           (byte_v),
    .SEND_READY_O          (rdy),
    .INIT_DONE_O           (idone),
    .PAGE_O                (page),
    .COLUMN_O              (column),
    .LCD_SERIAL_CLOCK_O    (sclk),
    .LCD_SLAVE_SELECT_N_O  (ss_n),
    .LCD_SERIAL_OUT_O      (mosi),
    .DATA_COMMAND_SELECT_O (dc),
    .LCD_RESET_N_O         (lrst_n),
    .BACKLIGHT_ON_O        (bk)
  );
  slcdw_lcd_model lcd (.sclk_i(sclk), .ss_n_i(ss_n), .mosi_i(mosi), .dc_i(dc), .rst_n_i(lrst_n),
    .bk_i(bk), .lit_o(m_lit), .last_o(m_last), .last_dc_o(m_dc), .on_o(m_on), .page_o(m_page),
    .col_o(m_col), .cnt_o(m_cnt));
  always #2.5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one byte; waits for ready again so the model has decoded it
  task automatic send(input logic d, input logic [7:0] b);
    int i;
    @(negedge clk);
    vld = 1'b1;
    is_data = d;
    byte_v = b;
    for (i = 0; i < 600 && rdy !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    vld = 1'b0;
    for (i = 0; i < 600 && rdy !== 1'b1; i++) @(negedge clk);
    chk(rdy, 1'b1);
  endtask
  task automatic t_reset_init;
    int i;
    repeat (12) @(negedge clk);
    chk(lrst_n, 1'b0);
    rst_n = 1'b1;
    repeat (100) @(negedge clk);
    chk(rdy, 1'b0);
    for (i = 0; i < 6000 && idone !== 1'b1; i++) @(negedge clk);
    chk(idone, 1'b1);
    chk(lrst_n, 1'b1);
    chk(m_cnt, 8'h06);
    chk(m_last, 8'hAF);
    chk(m_dc, 1'b0);
    chk(m_on, 1'b1);
  endtask
  task automatic t_backlight;
    bk_req = 1'b1;
    repeat (2) @(negedge clk);
    chk(m_lit, 1'b1);
    bk_req = 1'b0;
    repeat (2) @(negedge clk);
    chk(bk, 1'b0);
  endtask
  // page 3 and the top column, then two data bytes back to back, then the top page code
  task automatic t_address_data;
    send(1'b0, 8'hB3);
    chk(m_page, 3'h3);
    chk(page, 3'h3);
    send(1'b0, 8'h18);
    chk(m_col, 8'h18);
    send(1'b1, 8'hA5);
    send(1'b1, 8'h3C);
    chk(m_last, 8'h3C);
    chk(m_dc, 1'b1);
    chk(m_col, 8'h1A);
    chk(column, 8'h1A);
    send(1'b0, 8'hB8);
    chk(page, 3'h0);
    chk(m_page, 3'h0);
  endtask
  // range edges of the other commands; none may move the column
  task automatic t_commands;
    logic [7:0] codes [5] = '{8'hCF, 8'h28, 8'h7F, 8'hAE, 8'hAF};
    foreach (codes[k]) begin
      send(1'b0, codes[k]);
      chk(m_last, codes[k]);
      chk(m_dc, 1'b0);
      chk(m_on, k == 3 ? 1'b0 : 1'b1);
      chk(m_col, 8'h1A);
    end
  endtask
  // reset in mid-frame: pins go idle at once, then init runs again
  task automatic t_mid_reset;
    int i;
    @(negedge clk);
    vld = 1'b1;
    is_data = 1'b1;
    byte_v = 8'hFF;
    @(negedge clk);
    vld = 1'b0;
    repeat (100) @(negedge clk);
    chk(ss_n, 1'b0);
    rst_n = 1'b0;
    @(negedge clk);
    chk(ss_n, 1'b1);
    chk(sclk, 1'b0);
    chk(lrst_n, 1'b0);
    chk(idone, 1'b0);
    chk(rdy, 1'b0);
    repeat (11) @(negedge clk);
    rst_n = 1'b1;
    for (i = 0; i < 6000 && idone !== 1'b1; i++) @(negedge clk);
    chk(idone, 1'b1);
    chk(m_cnt, 8'h06);
    chk(m_on, 1'b1);
    chk(m_col, 8'h00);
    chk(column, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // a hang well past the expected run ends as a failure
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    bk_req = 1'b0;
    vld = 1'b0;
    is_data = 1'b0;
    byte_v = 8'h00;
    t_reset_init();
    t_backlight();
    t_address_data();
    t_commands();
    t_mid_reset();
    tally_and_finish();
  end
endmodule
